//--- logic/pcgsr_pkg.sv
// Purpose: shared constants for the peripheral clock gate and soft reset
// Assumes: 32-bit classic Wishbone register bus, byte addresses
// Notes: offsets are byte addresses of aligned words
package pcgsr_pkg;
	// register offsets
	localparam logic [11:0] OFS_SRC0 = 12'h040;
	localparam logic [11:0] OFS_SRC1 = 12'h044;
	localparam logic [11:0] OFS_SRC2 = 12'h048;
	localparam logic [11:0] OFS_MODE_CTRL = 12'h060;
	localparam logic [11:0] OFS_GATE_STAT = 12'h064;
	localparam logic [11:0] OFS_RUN_GATE = 12'h108;
	localparam logic [11:0] OFS_SLP_GATE = 12'h118;
	localparam logic [11:0] OFS_DSL_GATE = 12'h128;
	// writable bits of each register
	localparam logic [31:0] SRC0_MASK = 32'h0000_0008;
	localparam logic [31:0] SRC1_MASK = 32'h0707_1013;
	localparam logic [31:0] SRC2_MASK = 32'h0000_001f;
	localparam logic [31:0] GATE_MASK = 32'h0000_001f;
	localparam logic [31:0] MODE_MASK = 32'h0000_0001;
	// values after reset
	localparam logic [31:0] SRC_RST = 32'h0000_0000;
	localparam logic [4:0] GATE_RST = 5'h00;
	localparam logic ACG_RST = 1'b0;
	// field positions
	localparam int WDT_BIT = 3;
	localparam int COMP_LSB = 24;
	localparam int TMR_LSB = 16;
	localparam int TWI_BIT = 12;
	localparam int SSI_BIT = 4;
	localparam int ASY_LSB = 0;
	localparam int ACG_BIT = 0;
	localparam int STAT_MODE_LSB = 8;
	localparam int PORT_COUNT = 5;
	// power modes
	typedef enum logic [1:0] {
		PCGSR_RUN = 2'b00,
		PCGSR_SLEEP = 2'b01,
		PCGSR_DEEP = 2'b10
	} pcgsr_mode_e;
endpackage

//--- logic/pcgsr_gate_sel.sv
// Purpose: picks which gating register drives the port clocks
// Assumes: mode requests come from logic on the same clock
// Notes: deep sleep outranks sleep when both are requested
`timescale 1ns/1ns
`default_nettype none
module pcgsr_gate_sel (
	input wire logic [4:0] run_gate_i,
	input wire logic [4:0] slp_gate_i,
	input wire logic [4:0] dsl_gate_i,
	input wire logic acg_i,
	input wire logic sleep_i,
	input wire logic deep_i,
	output logic [4:0] gate_o,
	output pcgsr_pkg::pcgsr_mode_e mode_o
);
	// without auto gating the run settings always apply
	always_comb begin
		if (acg_i && deep_i) begin
			mode_o = pcgsr_pkg::PCGSR_DEEP; // R4
			gate_o = dsl_gate_i; // R5
		end else if (acg_i && sleep_i) begin
			mode_o = pcgsr_pkg::PCGSR_SLEEP;
			gate_o = slp_gate_i; // R5
		end else begin
			mode_o = pcgsr_pkg::PCGSR_RUN;
			gate_o = run_gate_i; // R5
		end
	end
endmodule
`default_nettype wire

//--- logic/pcgsr_top.sv
// Purpose: port clock gating and peripheral soft reset control
// Assumes: classic Wishbone slave, one clock, synchronous reset
// Notes: capability masks and power mode requests are same-clock inputs
//
// How it works
// R1 - gate bit one clocks unit, zero stops it
// R2 - access to unclocked unit answers bus fault
// R3 - all gate bits zero after reset
// R4 - run, sleep, deep-sleep gate registers kept
// R5 - sleep registers apply only with auto gating
// R6 - deep-sleep gate bits 4:0, rest read zero
// R7 - software preserves reserved bits on updates
// R8 - capability masks gate soft reset writes
// R9 - reset register zero bit 3 is watchdog
// R10 - register one bits 26:24 are comparators
// R11 - register one bits 18:16 are counters
// R12 - bit 12 two-wire, bit 4 sync serial
// R13 - bits 1:0 async serial, reserved read zero
// R14 - register two bits 4:0 are ports
// R15 - deep gate and register one reset zero
// R16 - reset bit holds unit until cleared
`timescale 1ns/1ns
`default_nettype none
module pcgsr_top (
	input wire logic core_clk_i,
	input wire logic sys_rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [11:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	output logic wb_err_o,
	input wire logic [31:0] capability_mask_one_i,
	input wire logic [31:0] capability_mask_two_i,
	input wire logic [31:0] capability_mask_four_i,
	input wire logic sleep_req_i,
	input wire logic deep_sleep_req_i,
	input wire logic periph_req_i,
	input wire logic [4:0] periph_port_sel_i,
	output logic periph_fault_o,
	output logic [4:0] port_clk_en_o,
	output logic watchdog_rst_o,
	output logic [2:0] comparator_rst_o,
	output logic [2:0] gp_counter_rst_o,
	output logic two_wire_rst_o,
	output logic sync_serial_rst_o,
	output logic [1:0] async_serial_rst_o,
	output logic [4:0] io_port_rst_o
);
	typedef struct packed {
		logic ack;
		logic err;
		logic [31:0] rdat;
		logic [31:0] src0;
		logic [31:0] src1;
		logic [31:0] src2;
		logic [4:0] run_gate;
		logic [4:0] slp_gate;
		logic [4:0] dsl_gate;
		logic auto_clock_gating;
		logic [4:0] clk_en;
		logic fault;
	} pcgsr_state_s;

	pcgsr_state_s st;
	pcgsr_state_s next_st;
	logic [4:0] eff_gate;
	pcgsr_pkg::pcgsr_mode_e eff_mode;
	logic bus_req;
	logic bus_wr;
	logic mapped;
	logic [31:0] wmask;

	// word address match
	function automatic logic addr_hit(input logic [11:0] adr,
		input logic [11:0] ofs);
		addr_hit = (adr[11:2] == ofs[11:2]);
	endfunction

	// every decoded offset
	function automatic logic is_mapped(input logic [11:0] adr);
		is_mapped = addr_hit(adr, pcgsr_pkg::OFS_SRC0) ||
			addr_hit(adr, pcgsr_pkg::OFS_SRC1) ||
			addr_hit(adr, pcgsr_pkg::OFS_SRC2) ||
			addr_hit(adr, pcgsr_pkg::OFS_MODE_CTRL) ||
			addr_hit(adr, pcgsr_pkg::OFS_GATE_STAT) ||
			addr_hit(adr, pcgsr_pkg::OFS_RUN_GATE) ||
			addr_hit(adr, pcgsr_pkg::OFS_SLP_GATE) ||
			addr_hit(adr, pcgsr_pkg::OFS_DSL_GATE);
	endfunction

	// byte enables widened to a bit mask
	function automatic logic [31:0] lane_mask(input logic [3:0] sel);
		lane_mask = 32'h0000_0000;
		for (int i = 0; i < 4; i++) begin
			lane_mask[i*8 +: 8] = {8{sel[i]}};
		end
	endfunction

	// replace only bits both enabled and writable
	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] wdat, input logic [31:0] allow);
		merge = (old & ~allow) | (wdat & allow);
	endfunction

	// five-bit gate update, reserved bits are never stored
	function automatic logic [4:0] gate_merge(input logic [4:0] old,
		input logic [31:0] wdat, input logic [31:0] allow);
		gate_merge = (old & ~allow[4:0]) | (wdat[4:0] & allow[4:0]);
	endfunction

	pcgsr_gate_sel u_gate_sel (
		.run_gate_i(st.run_gate),
		.slp_gate_i(st.slp_gate),
		.dsl_gate_i(st.dsl_gate),
		.acg_i(st.auto_clock_gating),
		.sleep_i(sleep_req_i),
		.deep_i(deep_sleep_req_i),
		.gate_o(eff_gate),
		.mode_o(eff_mode)
	);

	// bus request decode, one answer per request
	assign bus_req = wb_cyc_i && wb_stb_i && !st.ack && !st.err;
	assign bus_wr = bus_req && wb_we_i;
	assign mapped = is_mapped(wb_adr_i);
	assign wmask = lane_mask(wb_sel_i);

	// next state: registers, read data, gating and fault
	always_comb begin
		next_st = st;
		next_st.ack = bus_req && mapped;
		next_st.err = bus_req && !mapped;
		next_st.rdat = 32'h0000_0000;
		next_st.clk_en = eff_gate; // R1
		next_st.fault = periph_req_i &&
			((periph_port_sel_i & ~st.clk_en) != 5'h00); // R2
		if (bus_req && mapped && !wb_we_i) begin
			case (wb_adr_i[11:2])
				pcgsr_pkg::OFS_SRC0[11:2]: next_st.rdat = st.src0;
				pcgsr_pkg::OFS_SRC1[11:2]: next_st.rdat = st.src1;
				pcgsr_pkg::OFS_SRC2[11:2]: next_st.rdat = st.src2;
				pcgsr_pkg::OFS_MODE_CTRL[11:2]: begin
					next_st.rdat[pcgsr_pkg::ACG_BIT] = st.auto_clock_gating;
				end
				pcgsr_pkg::OFS_GATE_STAT[11:2]: begin
					next_st.rdat[4:0] = st.clk_en;
					next_st.rdat[pcgsr_pkg::STAT_MODE_LSB +: 2] = eff_mode;
				end
				pcgsr_pkg::OFS_RUN_GATE[11:2]: next_st.rdat[4:0] = st.run_gate;
				pcgsr_pkg::OFS_SLP_GATE[11:2]: next_st.rdat[4:0] = st.slp_gate;
				pcgsr_pkg::OFS_DSL_GATE[11:2]: begin
					next_st.rdat[4:0] = st.dsl_gate; // R6
				end
				default: next_st.rdat = 32'h0000_0000;
			endcase
		end
		if (bus_wr && mapped) begin
			case (wb_adr_i[11:2])
				pcgsr_pkg::OFS_SRC0[11:2]: begin
					next_st.src0 = merge(st.src0, wb_dat_i, wmask &
						pcgsr_pkg::SRC0_MASK & capability_mask_one_i); // R8 R9
				end
				pcgsr_pkg::OFS_SRC1[11:2]: begin
					next_st.src1 = merge(st.src1, wb_dat_i, wmask &
						pcgsr_pkg::SRC1_MASK & capability_mask_two_i); // R8 R13
				end
				pcgsr_pkg::OFS_SRC2[11:2]: begin
					next_st.src2 = merge(st.src2, wb_dat_i, wmask &
						pcgsr_pkg::SRC2_MASK & capability_mask_four_i); // R8 R14
				end
				pcgsr_pkg::OFS_MODE_CTRL[11:2]: begin
					if (wmask[pcgsr_pkg::ACG_BIT] &&
						pcgsr_pkg::MODE_MASK[pcgsr_pkg::ACG_BIT]) begin
						next_st.auto_clock_gating = wb_dat_i[pcgsr_pkg::ACG_BIT]; // R5
					end
				end
				pcgsr_pkg::OFS_RUN_GATE[11:2]: begin
					next_st.run_gate = gate_merge(st.run_gate, wb_dat_i,
						wmask & pcgsr_pkg::GATE_MASK); // R4
				end
				pcgsr_pkg::OFS_SLP_GATE[11:2]: begin
					next_st.slp_gate = gate_merge(st.slp_gate, wb_dat_i,
						wmask & pcgsr_pkg::GATE_MASK); // R4
				end
				pcgsr_pkg::OFS_DSL_GATE[11:2]: begin
					next_st.dsl_gate = gate_merge(st.dsl_gate, wb_dat_i,
						wmask & pcgsr_pkg::GATE_MASK); // R6
				end
				default: next_st.auto_clock_gating = st.auto_clock_gating;
			endcase
		end
	end

	// state register with synchronous reset
	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			st.ack <= 1'b0;
			st.err <= 1'b0;
			st.rdat <= 32'h0000_0000;
			st.src0 <= pcgsr_pkg::SRC_RST;
			st.src1 <= pcgsr_pkg::SRC_RST; // R15
			st.src2 <= pcgsr_pkg::SRC_RST;
			st.run_gate <= pcgsr_pkg::GATE_RST; // R3
			st.slp_gate <= pcgsr_pkg::GATE_RST; // R3
			st.dsl_gate <= pcgsr_pkg::GATE_RST; // R15
			st.auto_clock_gating <= pcgsr_pkg::ACG_RST;
			st.clk_en <= pcgsr_pkg::GATE_RST; // R3
			st.fault <= 1'b0;
		end else begin
			st <= next_st;
		end
	end

	// outputs taken straight from the state flops
	assign wb_ack_o = st.ack;
	assign wb_err_o = st.err;
	assign wb_dat_o = st.rdat;
	assign periph_fault_o = st.fault;
	assign port_clk_en_o = st.clk_en;
	// reset lines stay asserted until software clears the bit
	assign watchdog_rst_o = st.src0[pcgsr_pkg::WDT_BIT]; // R9 R16
	assign comparator_rst_o = st.src1[pcgsr_pkg::COMP_LSB +: 3]; // R10
	assign gp_counter_rst_o = st.src1[pcgsr_pkg::TMR_LSB +: 3]; // R11
	assign two_wire_rst_o = st.src1[pcgsr_pkg::TWI_BIT]; // R12
	assign sync_serial_rst_o = st.src1[pcgsr_pkg::SSI_BIT]; // R12
	assign async_serial_rst_o = st.src1[pcgsr_pkg::ASY_LSB +: 2]; // R13
	assign io_port_rst_o = st.src2[4:0]; // R14 R16

	// checks on the bus answer, gating, faults and soft reset registers
	sequence s_new_req;
		wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
	endsequence

	sequence s_src1_write;
		s_new_req ##0 wb_we_i ##0 addr_hit(wb_adr_i, pcgsr_pkg::OFS_SRC1);
	endsequence

	a_ack_one_cycle: assert property (@(posedge core_clk_i)
		disable iff (sys_rst_i) wb_ack_o |=> !wb_ack_o)
		else $error("ack held longer than one cycle");

	a_unmapped_err: assert property (@(posedge core_clk_i)
		disable iff (sys_rst_i) s_new_req ##0 !is_mapped(wb_adr_i)
		|=> wb_err_o && !wb_ack_o)
		else $error("unmapped access not answered with error");

	a_gates_after_reset: assert property (@(posedge core_clk_i) // R3
		$fell(sys_rst_i) |-> port_clk_en_o == 5'h00 &&
		st.dsl_gate == 5'h00 && st.src1 == 32'h0000_0000)
		else $error("gate or reset register not zero after reset");

	a_deep_gate_used: assert property (@(posedge core_clk_i) // R5
		disable iff (sys_rst_i) st.auto_clock_gating && deep_sleep_req_i
		|=> port_clk_en_o == $past(st.dsl_gate))
		else $error("deep sleep gate not applied");

	a_run_gate_used: assert property (@(posedge core_clk_i) // R4
		disable iff (sys_rst_i) !st.auto_clock_gating
		|=> port_clk_en_o == $past(st.run_gate))
		else $error("run gate not applied without auto gating");

	a_fault_on_gated: assert property (@(posedge core_clk_i) // R2
		disable iff (sys_rst_i)
		periph_req_i && ((periph_port_sel_i & ~port_clk_en_o) != 5'h00)
		|=> periph_fault_o)
		else $error("access to unclocked port without fault");

	a_no_fault_clocked: assert property (@(posedge core_clk_i) // R1
		disable iff (sys_rst_i)
		!periph_req_i || ((periph_port_sel_i & ~port_clk_en_o) == 5'h00)
		|=> !periph_fault_o)
		else $error("fault raised for a clocked port");

	a_reserved_zero: assert property (@(posedge core_clk_i) // R13
		disable iff (sys_rst_i)
		(st.src1 & ~pcgsr_pkg::SRC1_MASK) == 32'h0000_0000 &&
		(wb_dat_o[31:5] == 27'h000_0000 || !$past(addr_hit(wb_adr_i,
		pcgsr_pkg::OFS_DSL_GATE))))
		else $error("reserved bits not zero");

	a_cap_mask_write: assert property (@(posedge core_clk_i) // R8
		disable iff (sys_rst_i) s_src1_write
		|=> ((st.src1 ^ $past(st.src1)) & ~$past(capability_mask_two_i))
		== 32'h0000_0000)
		else $error("write changed a bit outside the capability mask");

	a_reset_held: assert property (@(posedge core_clk_i) // R16
		disable iff (sys_rst_i)
		!(wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && !wb_err_o)
		|=> $stable(st.src0) && $stable(st.src1) && $stable(st.src2))
		else $error("soft reset bit changed without a write");

	// checks on gating selection, bus answers and register contents
	sequence s_dsl_write;
		s_new_req ##0 wb_we_i ##0
			addr_hit(wb_adr_i, pcgsr_pkg::OFS_DSL_GATE);
	endsequence

	a_sleep_gate_used: assert property (@(posedge core_clk_i) // R5
		disable iff (sys_rst_i)
		st.auto_clock_gating && sleep_req_i && !deep_sleep_req_i
		|=> port_clk_en_o == $past(st.slp_gate))
		else $error("sleep gate not applied");

	a_err_one_cycle: assert property (@(posedge core_clk_i)
		disable iff (sys_rst_i) wb_err_o |=> !wb_err_o)
		else $error("error held longer than one cycle");

	a_mapped_ack: assert property (@(posedge core_clk_i)
		disable iff (sys_rst_i) s_new_req ##0 is_mapped(wb_adr_i)
		|=> wb_ack_o && !wb_err_o)
		else $error("mapped access not acknowledged");

	a_idle_data_zero: assert property (@(posedge core_clk_i)
		disable iff (sys_rst_i) !wb_ack_o |-> wb_dat_o == 32'h0000_0000)
		else $error("read data driven outside an acknowledge");

	a_src0_reserved: assert property (@(posedge core_clk_i) // R9
		disable iff (sys_rst_i)
		(st.src0 & ~pcgsr_pkg::SRC0_MASK) == 32'h0000_0000)
		else $error("reserved bit set in reset register zero");

	a_src2_reserved: assert property (@(posedge core_clk_i) // R14
		disable iff (sys_rst_i)
		(st.src2 & ~pcgsr_pkg::SRC2_MASK) == 32'h0000_0000)
		else $error("reserved bit set in reset register two");

	a_unmapped_no_write: assert property (@(posedge core_clk_i)
		disable iff (sys_rst_i)
		s_new_req ##0 wb_we_i ##0 !is_mapped(wb_adr_i)
		|=> $stable(st.src0) && $stable(st.src1) && $stable(st.src2) &&
		$stable(st.dsl_gate) && $stable(st.auto_clock_gating))
		else $error("unmapped write changed a register");

	a_dsl_write_lands: assert property (@(posedge core_clk_i) // R6
		disable iff (sys_rst_i) s_dsl_write
		|=> st.dsl_gate == (($past(wb_dat_i[4:0]) & $past(wmask[4:0])) |
		($past(st.dsl_gate) & ~$past(wmask[4:0]))))
		else $error("deep sleep gate write not stored");

	a_ack_err_apart: assert property (@(posedge core_clk_i)
		disable iff (sys_rst_i) !(wb_ack_o && wb_err_o))
		else $error("acknowledge and error raised together");
endmodule
`default_nettype wire

//--- dv/pcgsr_top_test.sv
// Purpose: self-checking bench for port clock gating and soft reset control
// Assumes: classic Wishbone single cycles, one 25 MHz clock, sync reset
// Notes: every scenario is one task that drives the block and judges it
`timescale 1ns/1ns
`default_nettype none
module pcgsr_top_test;
	logic core_clk_i = 1'b0;
	logic sys_rst_i = 1'b1;
	logic wb_cyc_i = 1'b0;
	logic wb_stb_i = 1'b0;
	logic wb_we_i = 1'b0;
	logic [11:0] wb_adr_i = 12'h000;
	logic [3:0] wb_sel_i = 4'h0;
	logic [31:0] wb_dat_i = 32'h0000_0000;
	logic [31:0] wb_dat_o;
	logic wb_ack_o;
	logic wb_err_o;
	logic [31:0] cap_one = 32'hffff_ffff;
	logic [31:0] cap_two = 32'hffff_ffff;
	logic [31:0] cap_four = 32'hffff_ffff;
	logic sleep_req = 1'b0;
	logic deep_req = 1'b0;
	logic periph_req = 1'b0;
	logic [4:0] port_sel = 5'h00;
	logic periph_fault_o;
	logic [4:0] port_clk_en_o;
	logic watchdog_rst_o;
	logic [2:0] comparator_rst_o;
	logic [2:0] gp_counter_rst_o;
	logic two_wire_rst_o;
	logic sync_serial_rst_o;
	logic [1:0] async_serial_rst_o;
	logic [4:0] io_port_rst_o;
	int failures = 0;
	int num_checks = 0;

	// device under test, every pin connected
	pcgsr_top u_dut (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i),
		.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
		.wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o),
		.capability_mask_one_i(cap_one), .capability_mask_two_i(cap_two),
		.capability_mask_four_i(cap_four), .sleep_req_i(sleep_req),
		.deep_sleep_req_i(deep_req), .periph_req_i(periph_req),
		.periph_port_sel_i(port_sel), .periph_fault_o(periph_fault_o),
		.port_clk_en_o(port_clk_en_o), .watchdog_rst_o(watchdog_rst_o),
		.comparator_rst_o(comparator_rst_o),
		.gp_counter_rst_o(gp_counter_rst_o),
		.two_wire_rst_o(two_wire_rst_o),
		.sync_serial_rst_o(sync_serial_rst_o),
		.async_serial_rst_o(async_serial_rst_o),
		.io_port_rst_o(io_port_rst_o));

	// 40 ns clock
	always #20 core_clk_i = ~core_clk_i;

	// compare one value and count it
	task automatic check(input string what, input logic [31:0] exp,
		input logic [31:0] got);
		num_checks++;
		if (got !== exp) begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask

	// one classic cycle, held until ack or err is sampled high
	task automatic bus(input logic we, input logic [11:0] adr,
		input logic [31:0] wdat, output logic [31:0] rdat, output logic err);
		int n;
		n = 0;
		@(posedge core_clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= adr;
		wb_sel_i <= 4'hf;
		wb_dat_i <= wdat;
		do begin
			@(posedge core_clk_i);
			n++;
		end while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1 && n < 50);
		rdat = wb_dat_o;
		err = wb_err_o;
		check("bus answer", 32'h0000_0000, {31'h0000_0000, n >= 50});
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
	endtask

	task automatic wr(input logic [11:0] adr, input logic [31:0] dat);
		logic [31:0] r;
		logic e;
		bus(1'b1, adr, dat, r, e);
		check("write err", 32'h0000_0000, {31'h0000_0000, e});
	endtask

	task automatic rd(input string what, input logic [11:0] adr,
		input logic [31:0] exp);
		logic [31:0] r;
		logic e;
		bus(1'b0, adr, 32'h0000_0000, r, e);
		check("read err", 32'h0000_0000, {31'h0000_0000, e});
		check(what, exp, r);
	endtask

	// wait a few edges for level outputs to settle
	task automatic settle;
		repeat (3) @(posedge core_clk_i);
	endtask

	task automatic t_reset;
		rd("deep gate", pcgsr_pkg::OFS_DSL_GATE, 32'h0000_0000);
		rd("reset reg one", pcgsr_pkg::OFS_SRC1, 32'h0000_0000);
		check("clk en", 32'h0000_0000, {27'h000_0000, port_clk_en_o});
		$display("test reset done");
	endtask

	task automatic t_gate;
		wr(pcgsr_pkg::OFS_DSL_GATE, 32'hffff_ffff);
		rd("deep gate bits", pcgsr_pkg::OFS_DSL_GATE, 32'h0000_001f);
		wr(pcgsr_pkg::OFS_SLP_GATE, 32'h0000_0002);
		rd("run gate old", pcgsr_pkg::OFS_RUN_GATE, 32'h0000_0000);
		wr(pcgsr_pkg::OFS_RUN_GATE, 32'h0000_0001);
		settle();
		check("run gate", 32'h0000_0001, {27'h000_0000, port_clk_en_o});
		deep_req <= 1'b1;
		settle();
		check("no auto", 32'h0000_0001, {27'h000_0000, port_clk_en_o});
		wr(pcgsr_pkg::OFS_MODE_CTRL, 32'h0000_0001);
		settle();
		check("deep gate", 32'h0000_001f, {27'h000_0000, port_clk_en_o});
		rd("auto gating", pcgsr_pkg::OFS_MODE_CTRL, 32'h0000_0001);
		rd("deep status", pcgsr_pkg::OFS_GATE_STAT, 32'h0000_021f);
		deep_req <= 1'b0;
		sleep_req <= 1'b1;
		settle();
		check("sleep gate", 32'h0000_0002, {27'h000_0000, port_clk_en_o});
		rd("sleep status", pcgsr_pkg::OFS_GATE_STAT, 32'h0000_0102);
		sleep_req <= 1'b0;
		wr(pcgsr_pkg::OFS_MODE_CTRL, 32'h0000_0000);
		settle();
		check("back run", 32'h0000_0001, {27'h000_0000, port_clk_en_o});
		$display("test gate done");
	endtask

	// one request cycle to the ports named by sel
	task automatic fault(input logic [4:0] sel, input logic exp);
		@(posedge core_clk_i);
		periph_req <= 1'b1;
		port_sel <= sel;
		@(posedge core_clk_i);
		periph_req <= 1'b0;
		@(posedge core_clk_i);
		check("fault", {31'h0000_0000, exp}, {31'h0000_0000, periph_fault_o});
	endtask

	task automatic t_fault;
		fault(5'h01, 1'b0);
		fault(5'h02, 1'b1);
		fault(5'h10, 1'b1);
		$display("test fault done");
	endtask

	task automatic t_soft;
		wr(pcgsr_pkg::OFS_SRC1, 32'hffff_ffff);
		rd("reg one", pcgsr_pkg::OFS_SRC1, 32'h0707_1013);
		check("unit resets", 32'h0000_03ff, {22'h0, comparator_rst_o,
			gp_counter_rst_o, two_wire_rst_o, sync_serial_rst_o,
			async_serial_rst_o});
		wr(pcgsr_pkg::OFS_SRC1, 32'h0000_0000);
		settle();
		check("released", 32'h0000_0000, {22'h0, comparator_rst_o,
			gp_counter_rst_o, two_wire_rst_o, sync_serial_rst_o,
			async_serial_rst_o});
		wr(pcgsr_pkg::OFS_SRC0, 32'hffff_ffff);
		rd("reg zero", pcgsr_pkg::OFS_SRC0, 32'h0000_0008);
		check("watchdog", 32'h0000_0001, {31'h0000_0000, watchdog_rst_o});
		wr(pcgsr_pkg::OFS_SRC2, 32'hffff_ffff);
		rd("reg two", pcgsr_pkg::OFS_SRC2, 32'h0000_001f);
		check("ports", 32'h0000_001f, {27'h000_0000, io_port_rst_o});
		cap_one <= 32'h0000_0000;
		cap_two <= 32'h0000_0010;
		wr(pcgsr_pkg::OFS_SRC0, 32'h0000_0000);
		rd("masked zero", pcgsr_pkg::OFS_SRC0, 32'h0000_0008);
		wr(pcgsr_pkg::OFS_SRC1, 32'hffff_ffff);
		rd("masked one", pcgsr_pkg::OFS_SRC1, 32'h0000_0010);
		$display("test soft reset done");
	endtask

	task automatic t_unmapped;
		logic [31:0] r;
		logic e;
		bus(1'b0, 12'h200, 32'h0000_0000, r, e);
		check("unmapped err", 32'h0000_0001, {31'h0000_0000, e});
		bus(1'b1, 12'h300, 32'hffff_ffff, r, e);
		check("unmapped write err", 32'h0000_0001, {31'h0000_0000, e});
		$display("test unmapped done");
	endtask

	task automatic stop_test;
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	// main sequence
	initial begin
		repeat (6) @(posedge core_clk_i);
		sys_rst_i <= 1'b0;
		t_reset();
		t_gate();
		t_fault();
		t_soft();
		t_unmapped();
		// reset again mid-run: deep gate, reset register one and clock enables must return to zero
		sys_rst_i <= 1'b1;
		repeat (2) @(posedge core_clk_i);
		sys_rst_i <= 1'b0;
		t_reset();
		stop_test();
	end

	// watchdog, far beyond the hundred or so cycles the tests need
	initial begin
		#200000;
		failures++;
		stop_test();
	end
endmodule
`default_nettype wire
